// >>> pkg/split_phase_pkg.sv
// Constants and types for the split-phase clock and data recovery block
package split_phase_pkg;
	localparam int PERIOD_W      = 12;
	localparam int PHASE_W       = 16;
	localparam int HALF_BIT_INIT = 16'h0020;
	localparam int FIFO_DEPTH    = 8;
	localparam int SYNC_STAGES   = 2;

	typedef struct packed {
		logic bit_val;
		logic cell_edge;
	} rx_word_t;
endpackage

// >>> core/sync_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("DEPTH must be a power of two and at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
	logic             push, pop;

	always_comb begin
		in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
		out_valid = wr_q != rd_q;
		out_data  = mem[rd_q[AW-1:0]];
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wr_d      = push ? wr_q + 1'b1 : wr_q;
		rd_d      = pop ? rd_q + 1'b1 : rd_q;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_q[AW-1:0]] <= in_data;
	end
endmodule

// >>> core/split_phase_recovery.sv
// Split-phase clock and data recovery with tracking digital oscillator
`timescale 1ns/1ps
module split_phase_recovery #(
	parameter int PERIOD_W = split_phase_pkg::PERIOD_W,
	parameter int DEPTH    = split_phase_pkg::FIFO_DEPTH
) (
	input  wire logic CLK,
	input  wire logic RST_B,
	input  wire logic SER_IN,
	input  wire logic GATE_EN,
	input  wire logic DATA_READY,
	output logic      DATA_VALID,
	output logic      DATA_BIT,
	output logic      REC_CLK,
	output logic      EDGE_PULSE,
	output logic      OVERFLOW
);
	localparam int W = $bits(split_phase_pkg::rx_word_t);

	initial begin
		if (PERIOD_W < 4 || PERIOD_W > 15)
			$error("PERIOD_W must lie between 4 and 15");
	end

	// Input synchronisers
	logic [split_phase_pkg::SYNC_STAGES-1:0] in_sync_q, in_sync_d;
	logic [1:0]                              gate_sync_q, gate_sync_d;
	logic                                    din_q, din_d;
	logic                                    edge_q, edge_d;

	always_comb begin
		in_sync_d   = {in_sync_q[0], SER_IN};
		gate_sync_d = {gate_sync_q[0], GATE_EN};
		din_d       = in_sync_q[1];
		edge_d      = in_sync_q[1] ^ din_q;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			in_sync_q   <= '0;
			gate_sync_q <= '0;
			din_q       <= 1'b0;
			edge_q      <= 1'b0;
		end else begin
			in_sync_q   <= in_sync_d;
			gate_sync_q <= gate_sync_d;
			din_q       <= din_d;
			edge_q      <= edge_d;
		end
	end

	// Tracking oscillator: period estimate and phase counter
	logic [PERIOD_W-1:0] half_q, half_d;
	logic [PERIOD_W-1:0] ph_q, ph_d;
	logic                tick;
	logic                gated_edge;

	function automatic logic [PERIOD_W-1:0] avg(
		input logic [PERIOD_W-1:0] a,
		input logic [PERIOD_W-1:0] b
	);
		logic [PERIOD_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[PERIOD_W:1];
	endfunction

	always_comb begin
		gated_edge = edge_q && gate_sync_q[1];
		tick       = ph_q >= half_q - 1'b1;
		half_d     = half_q;
		ph_d       = tick ? '0 : ph_q + 1'b1;
		if (gated_edge) begin
			// Edge-only comparison: edge past mid_pt averages phase count into half period
			if (ph_q > (half_q >> 1))
				half_d = avg(half_q, ph_q + 1'b1);
			ph_d = '0;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			half_q <= PERIOD_W'(split_phase_pkg::HALF_BIT_INIT);
			ph_q   <= '0;
		end else begin
			half_q <= half_d;
			ph_q   <= ph_d;
		end
	end

	// Divider, clock shift and decision stages
	logic div2_stage_q, div2_stage_d;
	logic clock_shift_stage_q, clock_shift_stage_d;
	logic data_decision_stage_q, data_decision_stage_d;
	logic cell_start, mid_tick, sample_now, pulse_d;
	logic word_valid_q, word_valid_d, ovf_q, ovf_d;
	logic [PERIOD_W-1:0] mid_pt;

	always_comb begin
		mid_pt              = half_q >> 1;
		mid_tick            = ph_q == mid_pt;
		div2_stage_d        = tick ? ~div2_stage_q : div2_stage_q;
		// Loads inverted divider half a tick later, opposite phase
		clock_shift_stage_d = mid_tick ? ~div2_stage_q
			: clock_shift_stage_q;
		cell_start          = mid_tick && !div2_stage_q &&
			!clock_shift_stage_q;
		sample_now          = cell_start;
		// Low in first half means rising edge at mid cell: zero
		data_decision_stage_d = sample_now ? din_q
			: data_decision_stage_q;
		word_valid_d        = sample_now;
		pulse_d             = gated_edge;
		ovf_d               = ovf_q;
	end

	split_phase_pkg::rx_word_t in_word, out_word;
	logic fifo_in_ready, fifo_out_valid;

	always_comb begin
		in_word.bit_val   = data_decision_stage_d;
		in_word.cell_edge = 1'b1;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			div2_stage_q          <= 1'b0;
			clock_shift_stage_q   <= 1'b1;
			data_decision_stage_q <= 1'b0;
			word_valid_q          <= 1'b0;
			EDGE_PULSE            <= 1'b0;
			REC_CLK               <= 1'b0;
		end else begin
			div2_stage_q          <= div2_stage_d;
			clock_shift_stage_q   <= clock_shift_stage_d;
			data_decision_stage_q <= data_decision_stage_d;
			word_valid_q          <= word_valid_d;
			EDGE_PULSE            <= pulse_d;
			REC_CLK               <= clock_shift_stage_d;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			ovf_q <= 1'b0;
		else if (word_valid_d && !fifo_in_ready)
			ovf_q <= 1'b1;
		else
			ovf_q <= ovf_d;
	end

	sync_fifo #(
		.WIDTH(W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk      (CLK),
		.rst_b    (RST_B),
		.in_data  (in_word),
		.in_valid (word_valid_d),
		.in_ready (fifo_in_ready),
		.out_data (out_word),
		.out_valid(fifo_out_valid),
		.out_ready(DATA_READY && !DATA_VALID)
	);

	// Output register stage fed from FIFO head
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			DATA_VALID <= 1'b0;
			DATA_BIT   <= 1'b0;
			OVERFLOW   <= 1'b0;
		end else begin
			OVERFLOW <= ovf_q;
			if (DATA_VALID && DATA_READY)
				DATA_VALID <= 1'b0;
			else if (!DATA_VALID && fifo_out_valid && DATA_READY) begin
				DATA_VALID <= 1'b1;
				DATA_BIT   <= out_word.bit_val;
			end
		end
	end
endmodule

// >>> sim/split_phase_recovery_props.sv
// Assertion checker for the split-phase recovery block
`timescale 1ns/1ps
module split_phase_recovery_props (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic SER_IN,
	input wire logic GATE_EN,
	input wire logic DATA_READY,
	input wire logic DATA_VALID,
	input wire logic DATA_BIT,
	input wire logic REC_CLK,
	input wire logic EDGE_PULSE,
	input wire logic OVERFLOW
);
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!RST_B);
	a_pulse_one: assert property (EDGE_PULSE |=> !EDGE_PULSE)
		else $error("edge pulse too long");
	a_pulse_late: assert property (GATE_EN[*3] ##0 $changed(SER_IN)
		##1 GATE_EN[*3] |-> ##[0:2] EDGE_PULSE) else $error("edge missed");
	a_pulse_cause: assert property (EDGE_PULSE |->
		$past(SER_IN, 4) != $past(SER_IN, 5)) else $error("stray pulse");
	a_pulse_gated: assert property (!GATE_EN[*6] |-> !EDGE_PULSE)
		else $error("pulse while gated");
	a_valid_hold: assert property (DATA_VALID && !DATA_READY |=>
		DATA_VALID && $stable(DATA_BIT)) else $error("bit dropped");
	a_clk_high: assert property ($rose(REC_CLK) |=>
		REC_CLK ##[1:300] !REC_CLK) else $error("clock stuck high");
	a_clk_low: assert property ($fell(REC_CLK) |=>
		!REC_CLK ##[1:300] REC_CLK) else $error("clock stuck low");
	a_ovf_sticky: assert property (OVERFLOW |=> OVERFLOW)
		else $error("overflow cleared");
	cover property (EDGE_PULSE);
	cover property (DATA_VALID && DATA_READY);
	cover property ($rose(OVERFLOW));
endmodule
bind split_phase_recovery split_phase_recovery_props props (.CLK, .RST_B,
	.SER_IN, .GATE_EN, .DATA_READY, .DATA_VALID, .DATA_BIT, .REC_CLK,
	.EDGE_PULSE, .OVERFLOW);

// >>> sim/split_phase_tx.sv
// Remote transmitter model sending split-phase cells
`timescale 1ns/1ps
module split_phase_tx (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] half,
	input  wire logic       bit_in,
	output logic            take,
	output logic            ser
);
	logic [8:0] cnt_q;
	logic       b_q;
	assign take = cnt_q == 9'h000;
	// Zero is low then high, one is high then low
	assign ser = (!take && cnt_q <= {1'b0, half}) ? b_q : !b_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 9'h000;
			b_q   <= 1'b1;
		end else begin
			cnt_q <= (cnt_q >= {half, 1'b0} - 9'h001) ? 9'h000 : cnt_q + 9'h001;
			if (take)
				b_q <= bit_in;
		end
	end
endmodule

// >>> sim/split_phase_recovery_tb.sv
// Self-checking bench for the split-phase recovery block
`timescale 1ns/1ps
module split_phase_recovery_tb;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       gate_en = 1'b1;
	logic       ready = 1'b1;
	logic       tx_bit = 1'b0;
	logic       rnd = 1'b0;
	logic       chk = 1'b0;
	logic [7:0] half = 8'h20;
	logic       ser, valid, dbit, take, ovf, p;
	logic       q[$];
	int         err_count = 0;
	int         n_tests = 0;
	int         k;
	always #25 clk = ~clk;
	split_phase_tx tx (.clk(clk), .rst_b(rst_b), .half(half),
		.bit_in(tx_bit), .take(take), .ser(ser));
	split_phase_recovery dut (.CLK(clk), .RST_B(rst_b), .SER_IN(ser),
		.GATE_EN(gate_en), .DATA_READY(ready), .DATA_VALID(valid),
		.DATA_BIT(dbit), .REC_CLK(), .EDGE_PULSE(), .OVERFLOW(ovf));
	task check(input logic s, input logic e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("FAIL t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task end_sim;
		$display("compares %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Waits for the cell start, then queues the next bit
	task send(input logic b);
		for (k = 0; k < 300; k++) begin
			@(posedge clk);
			if (take)
				break;
		end
		#2;
		tx_bit = b;
		if (k == 300) begin
			err_count++;
			end_sim;
		end
	endtask
	always @(posedge clk)
		if (rnd)
			#2 ready = 1'($urandom_range(1, 0));
	always @(posedge clk)
		if (chk && valid === 1'b1 && ready === 1'b1 && q.size() > 0)
			check(dbit, q.pop_front());
	initial begin
		void'($urandom(74));
		repeat (6) @(posedge clk);
		#2 rst_b = 1'b1;
		for (int i = 0; i < 16; i++)
			send(i[0]);
		$display("preamble done");
		for (int i = 0; i < 40; i++) begin
			p = 1'($urandom_range(1, 0));
			send(p);
			q.push_back(p);
			if (i == 1) begin
				repeat (8) @(posedge clk);
				#2 chk = 1'b1;
				rnd = 1'b1;
			end
		end
		send(1'b0);
		for (k = 0; k < 2000 && q.size() > 0; k++)
			@(posedge clk);
		check(q.size() == 0, 1'b1);
		if (q.size() > 0) begin
			err_count++;
			end_sim;
		end
		$display("payload done");
		chk = 1'b0;
		rnd = 1'b0;
		repeat (2) @(posedge clk);
		#2 ready = 1'b0;
		gate_en = 1'b0;
		half = 8'h22;
		for (int i = 0; i < 14; i++)
			send(1'($urandom_range(1, 0)));
		check(ovf, 1'b1);
		$display("overflow done");
		end_sim;
	end
endmodule
